// File: core/pfc_regs.sv
`timescale 1ns/1ps

module pfc_regs (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        vco_tick_in,
  input  wire logic        ref_tick_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_rvalid_out,
  output logic [9:0]       product_base_out,
  output logic             product_odd_bit_out,
  output logic [2:0]       pump_setting_out,
  output logic             pump_code_bad_out,
  output logic [6:0]       ref_divisor_out,
  output logic [11:0]      p_total_out,
  output logic [7:0]       q_total_out,
  output logic             bank1_source_select_out,
  output logic [6:0]       bank1_divisor_out,
  output logic             bank2_source_select_out,
  output logic [6:0]       bank2_divisor_out,
  output logic [7:0]       load_capacitance_code_out,
  output logic             bank1_div2_tick_out,
  output logic             bank1_div3_tick_out,
  output logic             bank1_div4_tick_out,
  output logic             bank1_divn_tick_out,
  output logic             bank2_div2_tick_out,
  output logic             bank2_div3_tick_out,
  output logic             bank2_div4_tick_out,
  output logic             bank2_divn_tick_out
);

  // Every check below runs on the one clock and sleeps through reset
  default clocking pfc_cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  logic [9:0] product_base_reg;
  logic       product_odd_bit_reg;
  logic [2:0] pump_setting_reg;
  logic [6:0] ref_divisor_reg;
  logic       bank1_source_select_reg;
  logic [6:0] bank1_divisor_reg;
  logic       bank2_source_select_reg;
  logic [6:0] bank2_divisor_reg;
  logic [7:0] load_capacitance_code_reg;
  logic [11:0] p_total_reg;
  logic [7:0]  q_total_reg;
  logic        pump_code_bad_reg;
  logic [7:0]  rdata_next;

  // Write strobes per register
  logic wr_bank1;
  logic wr_cap;
  logic wr_pump;
  logic wr_mullo;
  logic wr_oddq;
  logic wr_bank2;

  assign wr_bank1 = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_BANK1);
  assign wr_cap   = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_CAP);
  assign wr_pump  = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_PUMP);
  assign wr_mullo = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_MULLO);
  assign wr_oddq  = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_ODDQ);
  assign wr_bank2 = reg_wr_in && (reg_addr_in == pfc_pkg::ADDR_BANK2);

  // Multiplier fields: pump code and base value
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pump_setting_reg <= pfc_pkg::RST_PUMP;
      product_base_reg <= pfc_pkg::RST_PB;
    end else begin
      if (wr_pump) begin
        pump_setting_reg <=
          reg_wdata_in[pfc_pkg::FLD_PUMP_HI:pfc_pkg::FLD_PUMP_LO];
        product_base_reg[9:8] <= reg_wdata_in[pfc_pkg::FLD_PBHI_HI:0];
      end
      if (wr_mullo) begin
        product_base_reg[7:0] <= reg_wdata_in;
      end
    end
  end

  // Odd bit and reference divisor share one register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      product_odd_bit_reg <= pfc_pkg::RST_ODD;
      ref_divisor_reg     <= pfc_pkg::RST_Q;
    end else if (wr_oddq) begin
      product_odd_bit_reg <= reg_wdata_in[pfc_pkg::FLD_ODD_BIT];
      ref_divisor_reg     <= reg_wdata_in[pfc_pkg::FLD_Q_HI:0];
    end
  end

  // Post-divider bank setup
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      bank1_source_select_reg <= pfc_pkg::RST_SRC;
      bank1_divisor_reg       <= pfc_pkg::RST_BANKDIV;
      bank2_source_select_reg <= pfc_pkg::RST_SRC;
      bank2_divisor_reg       <= pfc_pkg::RST_BANKDIV;
    end else begin
      if (wr_bank1) begin
        bank1_source_select_reg <= reg_wdata_in[pfc_pkg::FLD_SRC_BIT];
        bank1_divisor_reg <= reg_wdata_in[pfc_pkg::FLD_DIV_HI:0];
      end
      if (wr_bank2) begin
        bank2_source_select_reg <= reg_wdata_in[pfc_pkg::FLD_SRC_BIT];
        bank2_divisor_reg <= reg_wdata_in[pfc_pkg::FLD_DIV_HI:0];
      end
    end
  end

  // Crystal load capacitance code
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      load_capacitance_code_reg <= pfc_pkg::RST_CAP;
    end else if (wr_cap) begin
      load_capacitance_code_reg <= reg_wdata_in;
    end
  end

  // Reset images of the totals and the highest legal pump code
  localparam logic [11:0] P_TOTAL_RST =
    pfc_pkg::pfc_p_total(pfc_pkg::RST_PB, pfc_pkg::RST_ODD);
  localparam logic [7:0]  Q_TOTAL_RST = pfc_pkg::pfc_q_total(pfc_pkg::RST_Q);
  localparam logic [2:0]  PUMP_CODE_MAX = 3'h4;

  // Derived loop totals, one cycle behind the fields
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      p_total_reg       <= P_TOTAL_RST;
      q_total_reg       <= Q_TOTAL_RST;
      pump_code_bad_reg <= 1'b0;
    end else begin
      p_total_reg <= pfc_pkg::pfc_p_total(product_base_reg,
                                          product_odd_bit_reg);
      q_total_reg <= pfc_pkg::pfc_q_total(ref_divisor_reg);
      pump_code_bad_reg <= (pump_setting_reg > PUMP_CODE_MAX);
    end
  end

  // Read decode; the top bits of the pump register read fixed
  always_comb begin
    rdata_next = pfc_pkg::RD_UNMAPPED;
    if (reg_addr_in == pfc_pkg::ADDR_BANK1) begin
      rdata_next = {bank1_source_select_reg, bank1_divisor_reg};
    end else if (reg_addr_in == pfc_pkg::ADDR_CAP) begin
      rdata_next = load_capacitance_code_reg;
    end else if (reg_addr_in == pfc_pkg::ADDR_PUMP) begin
      rdata_next = {pfc_pkg::FIXED_PATTERN, pump_setting_reg,
                    product_base_reg[9:8]};
    end else if (reg_addr_in == pfc_pkg::ADDR_MULLO) begin
      rdata_next = product_base_reg[7:0];
    end else if (reg_addr_in == pfc_pkg::ADDR_ODDQ) begin
      rdata_next = {product_odd_bit_reg, ref_divisor_reg};
    end else if (reg_addr_in == pfc_pkg::ADDR_BANK2) begin
      rdata_next = {bank2_source_select_reg, bank2_divisor_reg};
    end
  end

  // Read data held until the next read
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out  <= pfc_pkg::RD_UNMAPPED;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_next;
      end
    end
  end

  // Field outputs come straight from their registers
  assign product_base_out          = product_base_reg;
  assign product_odd_bit_out       = product_odd_bit_reg;
  assign pump_setting_out          = pump_setting_reg;
  assign pump_code_bad_out         = pump_code_bad_reg;
  assign ref_divisor_out           = ref_divisor_reg;
  assign p_total_out               = p_total_reg;
  assign q_total_out               = q_total_reg;
  assign bank1_source_select_out   = bank1_source_select_reg;
  assign bank1_divisor_out         = bank1_divisor_reg;
  assign bank2_source_select_out   = bank2_source_select_reg;
  assign bank2_divisor_out         = bank2_divisor_reg;
  assign load_capacitance_code_out = load_capacitance_code_reg;

  // Two independent post-divider banks
  pfc_bank_div u_bank1 (
    .mclk_in         (mclk_in),
    .reset_in        (reset_in),
    .vco_tick_in     (vco_tick_in),
    .ref_tick_in     (ref_tick_in),
    .source_sel_in   (bank1_source_select_reg),
    .bank_divisor_in (bank1_divisor_reg),
    .div2_tick_out   (bank1_div2_tick_out),
    .div3_tick_out   (bank1_div3_tick_out),
    .div4_tick_out   (bank1_div4_tick_out),
    .divn_tick_out   (bank1_divn_tick_out)
  );

  pfc_bank_div u_bank2 (
    .mclk_in         (mclk_in),
    .reset_in        (reset_in),
    .vco_tick_in     (vco_tick_in),
    .ref_tick_in     (ref_tick_in),
    .source_sel_in   (bank2_source_select_reg),
    .bank_divisor_in (bank2_divisor_reg),
    .div2_tick_out   (bank2_div2_tick_out),
    .div3_tick_out   (bank2_div3_tick_out),
    .div4_tick_out   (bank2_div4_tick_out),
    .divn_tick_out   (bank2_divn_tick_out)
  );

  // A read of the pump register
  sequence rd_pump_s;
    reg_rd_in && (reg_addr_in == pfc_pkg::ADDR_PUMP);
  endsequence

  // A read of the shared odd bit and divisor register
  sequence rd_oddq_s;
    reg_rd_in && (reg_addr_in == pfc_pkg::ADDR_ODDQ);
  endsequence

  // A read of the bank one register
  sequence rd_bank1_s;
    reg_rd_in && (reg_addr_in == pfc_pkg::ADDR_BANK1);
  endsequence

  // High base bits, a quiet cycle, then the low base bits
  sequence base_pair_s;
    wr_pump ##1 !wr_pump ##1 wr_mullo;
  endsequence

  fixed_bits_a: assert property (rd_pump_s |=> reg_rvalid_out &&
    reg_rdata_out[pfc_pkg::FLD_FIXED_HI:pfc_pkg::FLD_FIXED_LO]
      == pfc_pkg::FIXED_PATTERN)
    else $error("fixed pump register bits changed");

  ptotal_calc_a: assert property (1'b1 |=>
    p_total_out == ({2'h0, $past(product_base_out)} + 12'h004) * 12'h002
                   + {11'h000, $past(product_odd_bit_out)})
    else $error("multiplier total wrong");

  ptotal_range_a: assert property (
    (p_total_out >= pfc_pkg::P_TOTAL_MIN) &&
    (p_total_out <= pfc_pkg::P_TOTAL_MAX))
    else $error("multiplier total out of range");

  base_write_a: assert property (base_pair_s |=>
    product_base_out == {$past(reg_wdata_in[1:0], 3), $past(reg_wdata_in)})
    else $error("product base not assembled");

  pump_write_a: assert property (wr_pump |=>
    pump_setting_out == $past(reg_wdata_in[4:2]))
    else $error("pump code not stored");

  pump_flag_a: assert property (1'b1 |=>
    pump_code_bad_out == ($past(pump_setting_out) > 3'h4))
    else $error("pump code flag wrong");

  oddq_write_a: assert property (wr_oddq |=>
    product_odd_bit_out == $past(reg_wdata_in[7]) &&
    ref_divisor_out == $past(reg_wdata_in[6:0]))
    else $error("odd bit or divisor not stored");

  oddq_read_a: assert property (rd_oddq_s |=> reg_rvalid_out &&
    reg_rdata_out == {$past(product_odd_bit_out), $past(ref_divisor_out)})
    else $error("odd bit and divisor read back wrong");

  qtotal_calc_a: assert property (wr_oddq |=> ##1
    q_total_out == {1'b0, $past(reg_wdata_in[6:0], 2)} + 8'h02)
    else $error("reference divisor total wrong");

  bank_write_a: assert property (wr_bank1 |=>
    {bank1_source_select_out, bank1_divisor_out} == $past(reg_wdata_in))
    else $error("bank one setup not stored");

  bank1_read_a: assert property (rd_bank1_s |=> reg_rvalid_out &&
    reg_rdata_out == {$past(bank1_source_select_out),
                      $past(bank1_divisor_out)})
    else $error("bank one read back wrong");

  bank2_write_a: assert property (wr_bank2 |=>
    {bank2_source_select_out, bank2_divisor_out} == $past(reg_wdata_in))
    else $error("bank two setup not stored");

  cap_write_a: assert property (wr_cap ##1 !wr_cap |=>
    load_capacitance_code_out == $past(reg_wdata_in, 2))
    else $error("load capacitance not stored");

endmodule

// File: core/pfc_pkg.sv
package pfc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_BANK1 = 8'h0C;
  localparam logic [7:0] ADDR_CAP   = 8'h13;
  localparam logic [7:0] ADDR_PUMP  = 8'h40;
  localparam logic [7:0] ADDR_MULLO = 8'h41;
  localparam logic [7:0] ADDR_ODDQ  = 8'h42;
  localparam logic [7:0] ADDR_BANK2 = 8'h47;

  // Field positions
  localparam int FLD_SRC_BIT   = 7;
  localparam int FLD_DIV_HI    = 6;
  localparam int FLD_ODD_BIT   = 7;
  localparam int FLD_Q_HI      = 6;
  localparam int FLD_PUMP_HI   = 4;
  localparam int FLD_PUMP_LO   = 2;
  localparam int FLD_PBHI_HI   = 1;
  localparam int FLD_FIXED_HI  = 7;
  localparam int FLD_FIXED_LO  = 5;

  // Fixed pattern in the top bits of the pump register
  localparam logic [2:0] FIXED_PATTERN = 3'h6;

  // Reset values
  localparam logic [7:0] RST_CAP     = 8'h00;
  localparam logic [2:0] RST_PUMP    = 3'h0;
  localparam logic [9:0] RST_PB      = 10'h000;
  localparam logic       RST_ODD     = 1'b0;
  localparam logic [6:0] RST_Q       = 7'h00;
  localparam logic       RST_SRC     = 1'b0;
  localparam logic [6:0] RST_BANKDIV = 7'h08;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Loop arithmetic constants
  localparam logic [10:0] PB_OFFSET   = 11'h004;
  localparam logic [7:0]  Q_OFFSET    = 8'h02;
  localparam logic [11:0] P_TOTAL_MIN = 12'h008;
  localparam logic [11:0] P_TOTAL_MAX = 12'h807;

  // Fixed post-divider ratios, as terminal counts, and the programmable divider's count step
  localparam logic [0:0] DIV2_LAST = 1'h1;
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [6:0] DIVN_ONE  = 7'h01;

  // Multiplier total: twice the sum of the base and four, plus the odd bit
  function automatic logic [11:0] pfc_p_total(input logic [9:0] pb,
                                              input logic       po);
    logic [10:0] sum;
    sum = {1'b0, pb} + PB_OFFSET;
    return {sum, po};
  endfunction

  // Reference divisor total: field plus two
  function automatic logic [7:0] pfc_q_total(input logic [6:0] q);
    return {1'b0, q} + Q_OFFSET;
  endfunction

endpackage

// File: core/pfc_bank_div.sv
`timescale 1ns/1ps

module pfc_bank_div (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       vco_tick_in,
  input  wire logic       ref_tick_in,
  input  wire logic       source_sel_in,
  input  wire logic [6:0] bank_divisor_in,
  output logic            div2_tick_out,
  output logic            div3_tick_out,
  output logic            div4_tick_out,
  output logic            divn_tick_out
);

  // Every check below runs on the one clock and sleeps through reset
  default clocking bdv_cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  logic       sel_tick;
  logic [0:0] cnt2_reg;
  logic [1:0] cnt3_reg;
  logic [1:0] cnt4_reg;
  logic [6:0] cntn_reg;
  logic       divn_last;

  // Source mux: one picks the VCO, zero the reference
  assign sel_tick = source_sel_in ? vco_tick_in : ref_tick_in;

  // Divisors of zero or one pass every input tick
  assign divn_last = (cntn_reg + pfc_pkg::DIVN_ONE) >= bank_divisor_in;

  // Fixed and programmable dividers run on the selected tick
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt2_reg      <= '0;
      cnt3_reg      <= '0;
      cnt4_reg      <= '0;
      cntn_reg      <= '0;
      div2_tick_out <= 1'b0;
      div3_tick_out <= 1'b0;
      div4_tick_out <= 1'b0;
      divn_tick_out <= 1'b0;
    end else begin
      div2_tick_out <= sel_tick && (cnt2_reg == pfc_pkg::DIV2_LAST);
      div3_tick_out <= sel_tick && (cnt3_reg == pfc_pkg::DIV3_LAST);
      div4_tick_out <= sel_tick && (cnt4_reg == pfc_pkg::DIV4_LAST);
      divn_tick_out <= sel_tick && divn_last;
      if (sel_tick) begin
        cnt2_reg <= cnt2_reg + 1'b1;
        cnt3_reg <= (cnt3_reg == pfc_pkg::DIV3_LAST) ? 2'h0 : cnt3_reg + 2'h1;
        cnt4_reg <= cnt4_reg + 2'h1;
        cntn_reg <= divn_last ? 7'h00 : cntn_reg + pfc_pkg::DIVN_ONE;
      end
    end
  end

  // Four quiet cycles on the chosen source
  sequence quiet_src_s;
    (!sel_tick)[*4];
  endsequence

  no_src_pulse_a: assert property (quiet_src_s |=>
    !divn_tick_out && !div2_tick_out)
    else $error("divider pulsed without a source tick");

  div2_spacing_a: assert property (div2_tick_out |=> !div2_tick_out)
    else $error("divide by two pulsed twice in a row");

  // Every fourth tick is also an even tick, so the pulses coincide
  div4_in_step_a: assert property (div4_tick_out |-> div2_tick_out)
    else $error("divide by four out of step");

endmodule

// File: dv/pfc_host_model.sv
`timescale 1ns/1ps

// Host side: programs registers and supplies source clock ticks
module pfc_host_model (
  input  wire logic       mclk_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            vco_tick_out,
  output logic            ref_tick_out
);
  // Idle port and silent sources from time zero
  initial begin
    wr_out       = 1'b0;
    rd_out       = 1'b0;
    addr_out     = 8'h00;
    wdata_out    = 8'h00;
    vco_tick_out = 1'b0;
    ref_tick_out = 1'b0;
  end

  // One-cycle write strobe; released data stops showing the last value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge mclk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask

  // One-cycle read strobe, then a bounded wait for the answer
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    int i;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge mclk_in);
      rd_out <= 1'b0;
      #1;
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d  = rdata_in;
      end
    end
  endtask

  // Burst of back-to-back ticks: sel high pulses the VCO, low the reference
  task automatic emit(input logic sel, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      if (sel)
        vco_tick_out <= 1'b1;
      else
        ref_tick_out <= 1'b1;
    end
    @(posedge mclk_in);
    vco_tick_out <= 1'b0;
    ref_tick_out <= 1'b0;
  endtask
endmodule

// File: dv/pfc_regs_tb.sv
`timescale 1ns/1ps

module pfc_regs_tb;
  logic        mclk_in, reset_in, wr, rd, vt, rt, rvalid, odd, pbad;
  logic        s1, s2;
  logic [7:0]  addr, wdata, rdata, qt, cap, rv;
  wire  [7:0]  tk;
  logic [9:0]  pb;
  logic [2:0]  pump;
  logic [6:0]  qd, d1, d2;
  logic [11:0] pt;
  logic        ok;
  int          cnt [8];
  int          err_total, checks;
  logic [7:0]  ra [7] = '{8'h0C, 8'h13, 8'h40, 8'h41, 8'h42, 8'h47, 8'h43};
  logic [7:0]  re [7] = '{8'h08, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [7:0]  e1 [8] = '{8'h14, 8'h0D, 8'h0A, 8'h08, 8'h00, 8'h00, 8'h00,
                          8'h00};
  logic [7:0]  e2 [8] = '{8'h14, 8'h0D, 8'h0A, 8'h08, 8'h18, 8'h10, 8'h0C,
                          8'h06};

  pfc_host_model pfc_host_model_inst (
    .mclk_in(mclk_in), .rvalid_in(rvalid), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata), .vco_tick_out(vt),
    .ref_tick_out(rt));

  pfc_regs pfc_regs_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .vco_tick_in(vt),
    .ref_tick_in(rt), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .product_base_out(pb), .product_odd_bit_out(odd),
    .pump_setting_out(pump), .pump_code_bad_out(pbad),
    .ref_divisor_out(qd), .p_total_out(pt), .q_total_out(qt),
    .bank1_source_select_out(s1), .bank1_divisor_out(d1),
    .bank2_source_select_out(s2), .bank2_divisor_out(d2),
    .load_capacitance_code_out(cap), .bank1_div2_tick_out(tk[0]),
    .bank1_div3_tick_out(tk[1]), .bank1_div4_tick_out(tk[2]),
    .bank1_divn_tick_out(tk[3]), .bank2_div2_tick_out(tk[4]),
    .bank2_div3_tick_out(tk[5]), .bank2_div4_tick_out(tk[6]),
    .bank2_divn_tick_out(tk[7]));

  // 50 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // Count divider pulses since the last reset
  always @(posedge mclk_in or posedge reset_in) begin
    for (int k = 0; k < 8; k++)
      cnt[k] <= reset_in ? 0 : cnt[k] + int'(tk[k]);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    pfc_host_model_inst.read_reg(a, rv, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(rv), 16'(exp));
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    pfc_host_model_inst.write_reg(a, d);
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    err_total = 0;
    checks    = 0;
    reset_in  = 1'b1;
    do_reset();
    // Reset contents, fixed top bits and an unmapped read
    for (int i = 0; i < 7; i++) rchk(ra[i], re[i]);
    chk(16'(pt), 16'h0008);
    chk(16'(qt), 16'h0002);
    // Fields and totals; the fixed top bits refuse a wrong pattern
    wr_reg(8'h40, 8'h2D);
    wr_reg(8'h41, 8'h5A);
    wr_reg(8'h42, 8'h85);
    settle();
    chk(16'(pb), 16'h015A);
    chk(16'(pump), 16'h0003);
    chk(16'(odd), 16'h0001);
    chk(16'(qd), 16'h0005);
    chk(16'(pt), 16'h02BD);
    chk(16'(qt), 16'h0007);
    chk(16'(pbad), 16'h0000);
    rchk(8'h40, 8'hCD);
    rchk(8'h42, 8'h85);
    // Largest multiplier total with a forbidden pump code
    wr_reg(8'h40, 8'hD7);
    wr_reg(8'h41, 8'hFF);
    settle();
    chk(16'(pb), 16'h03FF);
    chk(16'(pt), 16'h0807);
    chk(16'(pbad), 16'h0001);
    // Bank and capacitance registers
    wr_reg(8'h0C, 8'h86);
    wr_reg(8'h47, 8'h10);
    wr_reg(8'h13, 8'hA5);
    settle();
    chk(16'(s1), 16'h0001);
    chk(16'(d1), 16'h0006);
    chk(16'(s2), 16'h0000);
    chk(16'(d2), 16'h0010);
    chk(16'(cap), 16'hA5);
    rchk(8'h0C, 8'h86);
    rchk(8'h47, 8'h10);
    // Write to an unmapped place changes nothing
    wr_reg(8'h43, 8'hFF);
    rchk(8'h43, 8'h00);
    rchk(8'h13, 8'hA5);
    // Post-dividers: bank one on reference, bank two on VCO
    do_reset();
    wr_reg(8'h0C, 8'h05);
    wr_reg(8'h47, 8'h88);
    pfc_host_model_inst.emit(1'b0, 40);
    settle();
    for (int k = 0; k < 8; k++) chk(16'(cnt[k]), 16'(e1[k]));
    pfc_host_model_inst.emit(1'b1, 48);
    settle();
    for (int k = 0; k < 8; k++) chk(16'(cnt[k]), 16'(e2[k]));
    final_report();
  end
endmodule
